//--- logic/ccuc_defs.vh
// register map, field positions and reset values of the cascaded capture channel
`ifndef CCUC_DEFS_VH
`define CCUC_DEFS_VH

// register indices; the byte address is four times the index
`define CCUC_IDX_START     16'hf030
`define CCUC_IDX_CTRL      16'hf040
`define CCUC_IDX_MODE      16'hf041
`define CCUC_IDX_IOCTL     16'hf042
`define CCUC_IDX_IRQEN     16'hf044
`define CCUC_IDX_STATUS    16'hf045
`define CCUC_IDX_UCOUNT    16'hf046
`define CCUC_IDX_UCAPT     16'hf048
`define CCUC_IDX_LCOUNT    16'hf056

// start register fields
`define CCUC_LOWER_RUN     2
`define CCUC_UPPER_RUN     1

// control register fields
`define CCUC_CLR_HI        6
`define CCUC_CLR_LO        5
`define CCUC_EDGE_HI       4
`define CCUC_EDGE_LO       3
`define CCUC_SRC_HI        2
`define CCUC_SRC_LO        0
`define CCUC_CLR_CAPTURE   2'h1
`define CCUC_EDGE_RISE     2'h0
`define CCUC_SRC_CASCADE   3'h7

// mode register
`define CCUC_MODE_HI       1
`define CCUC_MODE_LO       0
`define CCUC_MODE_NORMAL   2'h0

// io control register
`define CCUC_IO_HI         3
`define CCUC_IO_LO         0
`define CCUC_IO_CAP_RISE   4'h8

// irq enable and status bit positions
`define CCUC_OVF_BIT       4
`define CCUC_CAP_BIT       0

// reset values, counter maximum and half-word strobe pattern
`define CCUC_COUNT_RST     16'h0000
`define CCUC_CAPT_RST      16'hffff
`define CCUC_MAX_COUNT     16'hffff
`define CCUC_REG8_RST      8'h00
`define CCUC_STRB_HALF     4'h3

`endif

//--- logic/ccuc_top.v
// upper channel of a cascaded 32-bit capture timer with apb register access
//
// Overview of operation
// R1: lower start bit 2 set lets the lower counter count, clear holds it
// R2: upper start bit 1 set lets the upper counter count, clear stops it
// R3: clear field 01 in control bits 6:5 clears upper counter on capture
// R4: edge field 00 in control bits 4:3 counts on rising source edge
// R5: source field 111 advances upper counter once per lower counter overflow
// R6: mode field 00 places the channel in normal operation
// R7: io field 1000 captures on rising edge of the capture pin
// R8: overflow enable bit 4 gates overflow flag onto its request
// R9: capture enable bit 0 gates capture flag onto its request
// R10: overflow flag bit 4 sets when upper counter wraps ffff to 0000
// R11: overflow flag clears only by zero write after reading it set
// R12: capture flag bit 0 sets when counter is copied to capture register
// R13: capture flag clears only by zero write after reading it set
// R14: software writes can only clear status flags, never set them
// R15: upper counter is software readable, writable, resets to 0000
// R16: software accesses the upper counter only as 16-bit transfers
// R17: upper counter forms bits 31:16 of the cascaded count
// R18: lower counter counts every system clock, its wrap feeds upper counter
// R19: capture register is readable, writable, resets to ffff
// R20: each request is high while its flag and enable are both set
// R21: capture latches counter value before the counter is cleared
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccuc_defs.vh"

module ccuc_top #(
    parameter CNT_W = 16,
    parameter ADDR_W = 18
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // capture pin
    input wire upper_capture_pin_i,
    // interrupt requests and cascaded count
    output wire overflow_irq_request_o,
    output wire capture_irq_request_o,
    output wire [2*CNT_W-1:0] cascade_count_o
);

    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;

    reg [7:0] start_q;
    reg [7:0] ctrl_q;
    reg [7:0] mode_q;
    reg [7:0] ioctl_q;
    reg [7:0] irqen_q;

    reg [CNT_W-1:0] ucount_q;
    reg [CNT_W-1:0] ucount_d;
    reg [CNT_W-1:0] ucapt_q;
    reg [CNT_W-1:0] lcount_q;

    reg ovf_flag_q;
    reg ovf_flag_d;
    reg cap_flag_q;
    reg cap_flag_d;
    reg ovf_armed_q;
    reg cap_armed_q;
    reg ovf_irq_q;
    reg cap_irq_q;

    reg pin_s1_q;
    reg pin_s2_q;
    reg pin_s3_q;

    reg [31:0] rdata_d;
    reg hit_d;

    wire [ADDR_W-3:0] idx = paddr_i[ADDR_W-1:2];
    wire setup = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pready_q;
    wire wr = access & pwrite_i & ~pslverr_q;
    wire rd = access & ~pwrite_i & ~pslverr_q;
    wire full_half = (pstrb_i[1:0] == `CCUC_STRB_HALF);
    wire is_start = (idx == `CCUC_IDX_START);
    wire is_ctrl = (idx == `CCUC_IDX_CTRL);
    wire is_mode = (idx == `CCUC_IDX_MODE);
    wire is_ioctl = (idx == `CCUC_IDX_IOCTL);
    wire is_irqen = (idx == `CCUC_IDX_IRQEN);
    wire is_status = (idx == `CCUC_IDX_STATUS);
    wire is_ucount = (idx == `CCUC_IDX_UCOUNT);
    wire is_ucapt = (idx == `CCUC_IDX_UCAPT);
    wire is_lcount = (idx == `CCUC_IDX_LCOUNT);

    // per-register write strobes; 8-bit registers need byte lane 0
    wire wr_byte = wr & pstrb_i[0];
    wire wr_half = wr & full_half;
    wire wr_start = wr_byte & is_start;
    wire wr_ctrl = wr_byte & is_ctrl;
    wire wr_mode = wr_byte & is_mode;
    wire wr_ioctl = wr_byte & is_ioctl;
    wire wr_irqen = wr_byte & is_irqen;
    wire wr_status = wr_byte & is_status;
    wire wr_ucapt = wr_half & is_ucapt;
    wire wr_lcount = wr_half & is_lcount;
    // enable as it stands after this edge, so requests follow it at once
    wire [7:0] irqen_d = wr_irqen ? pwdata_i[7:0] : irqen_q;

    wire lower_count_run = start_q[`CCUC_LOWER_RUN];
    wire upper_count_run = start_q[`CCUC_UPPER_RUN];
    wire [1:0] clear_source = {ctrl_q[`CCUC_CLR_HI], ctrl_q[`CCUC_CLR_LO]};
    wire [1:0] count_edge = {ctrl_q[`CCUC_EDGE_HI], ctrl_q[`CCUC_EDGE_LO]};
    wire [2:0] clock_select = ctrl_q[`CCUC_SRC_HI:`CCUC_SRC_LO];
    wire [1:0] mode_sel = {mode_q[`CCUC_MODE_HI], mode_q[`CCUC_MODE_LO]};
    wire [3:0] capture_func = ioctl_q[`CCUC_IO_HI:`CCUC_IO_LO];
    wire normal_mode = (mode_sel == `CCUC_MODE_NORMAL); // R6

    // overflow pulse of the lower counter
    wire lower_wrap = lower_count_run & (lcount_q == `CCUC_MAX_COUNT); // R18
    // only the cascade source with rising edge is wired up in this channel
    wire upper_adv = upper_count_run & normal_mode & lower_wrap // R2
        & (clock_select == `CCUC_SRC_CASCADE) // R5
        & (count_edge == `CCUC_EDGE_RISE); // R4
    // pin edge only looked at after the two-stage synchroniser
    wire pin_rise = pin_s2_q & ~pin_s3_q;
    wire capture = pin_rise & normal_mode & (capture_func == `CCUC_IO_CAP_RISE); // R7
    wire cap_clear = capture & (clear_source == `CCUC_CLR_CAPTURE); // R3
    wire ucount_wr = wr & is_ucount & full_half; // R16
    wire ovf_event = upper_adv & ~cap_clear & ~ucount_wr
        & (ucount_q == `CCUC_MAX_COUNT); // R10

    // capture pin synchroniser, first stage read only by the second
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 1'b0;
        end else begin
            pin_s1_q <= upper_capture_pin_i;
        end
    end

    // second stage and edge-detect delay; both reset to the idle low pin level
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // read mux and address decode
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b1;
        if (is_start) begin
            rdata_d[7:0] = start_q;
        end else if (is_ctrl) begin
            rdata_d[7:0] = ctrl_q;
        end else if (is_mode) begin
            rdata_d[7:0] = mode_q;
        end else if (is_ioctl) begin
            rdata_d[7:0] = ioctl_q;
        end else if (is_irqen) begin
            rdata_d[7:0] = irqen_q;
        end else if (is_status) begin
            rdata_d[`CCUC_OVF_BIT] = ovf_flag_q;
            rdata_d[`CCUC_CAP_BIT] = cap_flag_q;
        end else if (is_ucount) begin
            rdata_d[CNT_W-1:0] = ucount_q; // R15
        end else if (is_ucapt) begin
            rdata_d[CNT_W-1:0] = ucapt_q; // R19
        end else if (is_lcount) begin
            rdata_d[CNT_W-1:0] = lcount_q;
        end else begin
            hit_d = 1'b0;
        end
    end

    // apb handshake: one wait-free access phase, answer registered in setup
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    // unmapped index answers with an error and has no side effect
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup & ~hit_d;
        end
    end

    // read data sampled in setup, so a read sees flags as of that cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rdata_d;
        end
    end

    // configuration registers, one byte each
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_q <= `CCUC_REG8_RST;
        end else if (wr_start) begin
            start_q <= pwdata_i[7:0]; // R1
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `CCUC_REG8_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata_i[7:0];
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= `CCUC_REG8_RST;
        end else if (wr_mode) begin
            mode_q <= pwdata_i[7:0];
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ioctl_q <= `CCUC_REG8_RST;
        end else if (wr_ioctl) begin
            ioctl_q <= pwdata_i[7:0];
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irqen_q <= `CCUC_REG8_RST;
        end else begin
            irqen_q <= irqen_d;
        end
    end

    // lower counter, runs on every system clock while started
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lcount_q <= `CCUC_COUNT_RST;
        end else if (wr_lcount) begin
            lcount_q <= pwdata_i[CNT_W-1:0];
        end else if (lower_count_run) begin
            lcount_q <= lcount_q + 1'b1; // R1
        end
    end

    // upper counter next value; software write wins over counting
    always @* begin
        ucount_d = ucount_q;
        if (ucount_wr) begin
            ucount_d = pwdata_i[CNT_W-1:0]; // R15
        end else if (cap_clear) begin
            ucount_d = `CCUC_COUNT_RST; // R3
        end else if (upper_adv) begin
            ucount_d = ucount_q + 1'b1; // R5
        end
    end

    // upper counter and capture register
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ucount_q <= `CCUC_COUNT_RST; // R15
            ucapt_q <= `CCUC_CAPT_RST; // R19
        end else begin
            ucount_q <= ucount_d;
            if (capture) begin
                // old count is taken, the clear only shows a cycle later
                ucapt_q <= ucount_q; // R21
            end else if (wr_ucapt) begin
                ucapt_q <= pwdata_i[CNT_W-1:0]; // R19
            end
        end
    end

    // overflow flag next value: set wins over the read-then-zero clear
    always @* begin
        ovf_flag_d = ovf_flag_q;
        if (wr_status & ovf_armed_q & ~pwdata_i[`CCUC_OVF_BIT]) begin
            ovf_flag_d = 1'b0; // R11
        end
        // writing one is never a set source
        if (ovf_event) begin
            ovf_flag_d = 1'b1; // R14
        end
    end

    // capture flag next value: set wins over the read-then-zero clear
    always @* begin
        cap_flag_d = cap_flag_q;
        if (wr_status & cap_armed_q & ~pwdata_i[`CCUC_CAP_BIT]) begin
            cap_flag_d = 1'b0; // R13
        end
        if (capture) begin
            cap_flag_d = 1'b1; // R12
        end
    end

    // status flags
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_flag_q <= 1'b0;
        end else begin
            ovf_flag_q <= ovf_flag_d; // R10
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_flag_q <= 1'b0;
        end else begin
            cap_flag_q <= cap_flag_d; // R12
        end
    end

    // a read seeing the flag set arms it; any status write disarms
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_armed_q <= 1'b0;
            cap_armed_q <= 1'b0;
        end else if (rd & is_status) begin
            ovf_armed_q <= ovf_flag_q; // R11
            cap_armed_q <= cap_flag_q; // R13
        end else if (wr_status) begin
            ovf_armed_q <= 1'b0;
            cap_armed_q <= 1'b0;
        end
    end

    // next-value form keeps requests in step with flags and enables
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_flag_d & irqen_d[`CCUC_OVF_BIT]; // R8 R20
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_irq_q <= 1'b0;
        end else begin
            cap_irq_q <= cap_flag_d & irqen_d[`CCUC_CAP_BIT]; // R9 R20
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign overflow_irq_request_o = ovf_irq_q;
    assign capture_irq_request_o = cap_irq_q;
    assign cascade_count_o = {ucount_q, lcount_q}; // R17

endmodule

`default_nettype wire

//--- verif/ccuc_pulse_src.sv
// pulse source model on the capture pin
`timescale 1ns/1ps
`default_nettype none
module ccuc_pulse_src (
    // clock and request
    input wire logic clk_i,
    input wire logic fire_i,
    // capture pin
    output logic pin_o
);
    logic [2:0] left_q = 3'h0;
    // four clocks high, above the two-clock minimum
    always @(posedge clk_i) begin
        if (fire_i) begin
            left_q <= 3'h4;
        end else if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
        end
    end
    assign pin_o = (left_q != 3'h0);
endmodule
`default_nettype wire

//--- verif/ccuc_checker_assertions.sv
// port assertions of the cascaded capture channel
`timescale 1ns/1ps
`default_nettype none
module ccuc_checker #(
    parameter CNT_W = 16,
    parameter ADDR_W = 18
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic upper_capture_pin_i,
    input wire logic overflow_irq_request_o,
    input wire logic capture_irq_request_o,
    input wire logic [2*CNT_W-1:0] cascade_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // any software write may move counters or flags
    wire wr = psel_i && penable_i && pwrite_i;
    wire [15:0] up = cascade_count_o[31:16];
    wire [15:0] lo = cascade_count_o[15:0];
    ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    ovf_rise_a: assert property ($rose(overflow_irq_request_o) |->
        $past(up) == 16'hffff || $past(wr)) else $error("overflow request without wrap");
    ovf_fall_a: assert property ($fell(overflow_irq_request_o) |-> $past(wr))
        else $error("overflow request dropped alone");
    cap_rise_a: assert property ($rose(capture_irq_request_o) |->
        $past(upper_capture_pin_i) || $past(wr)) else $error("capture request without pin");
    cap_clear_a: assert property ($rose(capture_irq_request_o) && !$past(wr) |-> up == 16'h0)
        else $error("counter not cleared by capture");
    cap_fall_a: assert property ($fell(capture_irq_request_o) |-> $past(wr))
        else $error("capture request dropped alone");
    upper_step_a: assert property (up == $past(up) + 16'h1 |->
        $past(lo) == 16'hffff || $past(wr)) else $error("upper step without lower wrap");
    lower_step_a: assert property (lo == $past(lo) || lo == $past(lo) + 16'h1 || $past(wr))
        else $error("lower counter jumped");
endmodule
bind ccuc_top ccuc_checker #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .upper_capture_pin_i(upper_capture_pin_i),
    .overflow_irq_request_o(overflow_irq_request_o),
    .capture_irq_request_o(capture_irq_request_o), .cascade_count_o(cascade_count_o));
`default_nettype wire

//--- verif/tb_cascaded_capture_upper_channel.sv
// self-checking bench of the cascaded capture channel
`timescale 1ns/1ps
`default_nettype none
`include "ccuc_defs.vh"
module tb_cascaded_capture_upper_channel;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic fire = 1'b0;
    logic [31:0] rd;
    logic err;
    wire [31:0] prdata;
    wire [31:0] cnt;
    wire pready, pslverr, pin, ovf, cap;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    ccuc_top u_dut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .upper_capture_pin_i(pin), .overflow_irq_request_o(ovf),
        .capture_irq_request_o(cap), .cascade_count_o(cnt));
    ccuc_pulse_src u_src (.clk_i(clk), .fire_i(fire), .pin_o(pin));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; waits for ready, a lost ready ends in the timeout
    task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_reset();
        apb(0, `CCUC_IDX_UCOUNT, 0);
        chk(rd, 32'h0);
        chk(err, 1'b0);
        // byte-wide write to the counter must be ignored
        pstrb <= 4'h1;
        apb(1, `CCUC_IDX_UCOUNT, 32'h5);
        pstrb <= 4'hf;
        apb(0, `CCUC_IDX_UCOUNT, 0);
        chk(rd, 32'h0);
        apb(0, `CCUC_IDX_UCAPT, 0);
        chk(rd, 32'hffff);
        apb(0, 16'hf03c, 0);
        chk(err, 1'b1);
    endtask
    task automatic t_config();
        apb(1, `CCUC_IDX_START, 0);
        apb(1, `CCUC_IDX_CTRL, 32'h27);
        apb(1, `CCUC_IDX_MODE, 32'h0);
        apb(1, `CCUC_IDX_IOCTL, 32'h8);
        apb(1, `CCUC_IDX_IRQEN, 32'h11);
        apb(0, `CCUC_IDX_CTRL, 0);
        chk(rd, 32'h27);
    endtask
    task automatic t_overflow();
        apb(1, `CCUC_IDX_LCOUNT, 32'hfff0);
        apb(1, `CCUC_IDX_UCOUNT, 32'hffff);
        apb(0, `CCUC_IDX_LCOUNT, 0);
        chk(rd, 32'hfff0);
        apb(1, `CCUC_IDX_START, 32'h6);
        while (ovf !== 1'b1) @(posedge clk);
        chk(cnt[31:16], 16'h0);
        apb(1, `CCUC_IDX_IRQEN, 32'h01);
        @(posedge clk);
        chk(ovf, 1'b0);
        apb(1, `CCUC_IDX_IRQEN, 32'h11);
        apb(1, `CCUC_IDX_STATUS, 0);
        @(posedge clk);
        chk(ovf, 1'b1);
        apb(0, `CCUC_IDX_STATUS, 0);
        chk(rd, 32'h10);
        apb(1, `CCUC_IDX_STATUS, 0);
        apb(1, `CCUC_IDX_STATUS, 32'h11);
        @(posedge clk);
        chk(ovf, 1'b0);
    endtask
    task automatic t_capture();
        // mode 01 must not capture
        apb(1, `CCUC_IDX_MODE, 32'h1);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (10) @(posedge clk);
        chk(cap, 1'b0);
        apb(1, `CCUC_IDX_MODE, 0);
        apb(1, `CCUC_IDX_LCOUNT, 0);
        apb(1, `CCUC_IDX_UCOUNT, 32'h1234);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        while (cap !== 1'b1) @(posedge clk);
        chk(cnt[31:16], 16'h0);
        apb(0, `CCUC_IDX_UCAPT, 0);
        chk(rd, 32'h1234);
        apb(1, `CCUC_IDX_IRQEN, 32'h10);
        @(posedge clk);
        chk(cap, 1'b0);
        apb(1, `CCUC_IDX_IRQEN, 32'h11);
        apb(0, `CCUC_IDX_STATUS, 0);
        chk(rd, 32'h1);
        apb(1, `CCUC_IDX_STATUS, 0);
        @(posedge clk);
        chk(cap, 1'b0);
    endtask
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_config();
        t_overflow();
        t_capture();
        summarize();
    end
endmodule
`default_nettype wire
